// file: rtl/scrp_regs.svh
`ifndef SCRP_REGS_SVH
`define SCRP_REGS_SVH

// command codes
`define SCRP_CMD_READ 8'h03
`define SCRP_CMD_WRITE 8'h02

// register offsets
`define SCRP_REG_START 8'h01
`define SCRP_REG_IRQ_STAT 8'h7c
`define SCRP_REG_IRQ_MASK 8'h7d
`define SCRP_ADDR_TOP 8'hff

// field positions
`define SCRP_START_RUN_BIT 0
`define SCRP_WAKE_BIT 4

// reset values
`define SCRP_START_RST 1'b1
`define SCRP_STAT_RST 5'h00
`define SCRP_MASK_RST 5'h00
`define SCRP_PIN_IDLE 4'h5

// timing
`define SCRP_SCK_MAX_HZ 25000000
`define SCRP_REF_HZ 25000000
`define SCRP_STRAP_WAIT 2'h3

`endif

// file: rtl/scrp_pkg.sv
package scrp_pkg;

    typedef enum logic [2:0] {
        st_cmd,
        st_addr_rd,
        st_addr_wr,
        st_read,
        st_write,
        st_skip
    } scrp_state_e;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic sdi;
        logic sdo;
    } scrp_pins_s;

    typedef logic [7:0] scrp_byte_t;

endpackage

// file: rtl/scrp_mem.sv
module scrp_mem (
    input logic ref_clk,
    input logic clk_en,
    input logic wr_en,
    input scrp_pkg::scrp_byte_t wr_addr,
    input scrp_pkg::scrp_byte_t wr_data,
    input scrp_pkg::scrp_byte_t rd_addr,
    output scrp_pkg::scrp_byte_t rd_data
);

    scrp_pkg::scrp_byte_t mem [0:255];

    // no reset on the array: contents are undefined until written
    always_ff @(posedge ref_clk) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // scrp_mem

// file: rtl/scrp_top.sv
// Function
// only read 03 and write 02 commands
// address counter increments after each byte
// burst read shifts out next address
// burst write stores to next address
// select high ends the operation
// host toggles select before new command
// address counter wraps top to zero
// serial clock at most 25 MHz; the oversampler needs it well below the 25 MHz ref_clk
// host keeps bursts fast enough
// data input sampled on rising edge
// data output changes on falling edge
// low output pin at strap selects client
// start bit resets one, zero stops
// random access to every register address
// mask bits enable interrupt conditions
// status bits record interrupt conditions
// reading status clears interrupt bits
// mask bit four enables wake output
// status bit four records wake, cleared
// active-low outputs follow masked status
// one address byte, msb first

`include "scrp_regs.svh"

module scrp_top (
    input logic ref_clk,
    input logic rst,
    input logic clk_en,
    input logic serial_clk,
    input logic client_select_n,
    input logic host_out_data,
    input logic serial_data_out_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input logic [3:0] irq_event,
    input logic wake_event,
    output logic switch_run,
    output logic irq_out_n,
    output logic wake_event_out_n
);

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic is_special(input scrp_pkg::scrp_byte_t a);
        is_special = (a == `SCRP_REG_START) || (a == `SCRP_REG_IRQ_STAT) ||
            (a == `SCRP_REG_IRQ_MASK);
    endfunction

    function automatic scrp_pkg::scrp_byte_t reg_read(input scrp_pkg::scrp_byte_t a,
        input logic st, input logic [4:0] stat, input logic [4:0] mask);
        if (a == `SCRP_REG_START) begin
            reg_read = {7'h00, st};
        end else if (a == `SCRP_REG_IRQ_STAT) begin
            reg_read = {3'h0, stat};
        end else if (a == `SCRP_REG_IRQ_MASK) begin
            reg_read = {3'h0, mask};
        end else begin
            reg_read = 8'h00;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    scrp_pkg::scrp_pins_s pin_raw, s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
    logic sck_rise, sck_fall, cs_act;
    logic client_mode_ff, strap_done_ff;
    logic [1:0] strap_cnt_ff;

    assign pin_raw = '{sck: serial_clk, cs_n: client_select_n, sdi: host_out_data,
        sdo: serial_data_out_in};

    // ref_clk oversamples the serial clock, so it must run well below ref_clk
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            localparam logic [3:0] IDLE = `SCRP_PIN_IDLE;
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    s1_ff[g] <= IDLE[g];
                    s2_ff[g] <= IDLE[g];
                    s3_ff[g] <= IDLE[g];
                    lvl_ff[g] <= IDLE[g];
                end else if (clk_en) begin
                    s1_ff[g] <= pin_raw[g];
                    s2_ff[g] <= s1_ff[g];
                    s3_ff[g] <= s2_ff[g];
                    lvl_ff[g] <= nxt_lvl[g];
                end
            end
            // a change counts only once stages two and three agree
            assign nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
        end
    endgenerate

    assign sck_rise = !lvl_ff.sck && nxt_lvl.sck;
    assign sck_fall = lvl_ff.sck && !nxt_lvl.sck;
    assign cs_act = client_mode_ff && !nxt_lvl.cs_n;

    ////////////////////////////////////////////////////////////////////////////
    // strap capture: waits for the synchroniser to settle after reset

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_cnt_ff <= 2'h0;
            strap_done_ff <= 1'b0;
            client_mode_ff <= 1'b0;
        end else if (clk_en && !strap_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == `SCRP_STRAP_WAIT) begin
                strap_done_ff <= 1'b1;
                // filtered level, the flop only catches up one edge later
                client_mode_ff <= !nxt_lvl.sdo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command, address and data sequencing

    scrp_pkg::scrp_state_e state_ff, nxt_state;
    logic [2:0] bit_cnt_ff, nxt_cnt;
    scrp_pkg::scrp_byte_t rx_ff, nxt_rx, rx_byte, addr_ff, nxt_addr, addr_inc;
    scrp_pkg::scrp_byte_t mem_rdata, rd_byte, tx_ff;
    logic byte_done, wr_hit, rd_load, rd_shift, mem_wr, sdo_ff;
    logic start_ff;
    logic [4:0] stat_ff, mask_ff, stat_clr, nxt_stat;
    logic irq_n_ff, wake_n_ff;

    assign rx_byte = {rx_ff[6:0], nxt_lvl.sdi};
    assign byte_done = sck_rise && (bit_cnt_ff == 3'h7);
    assign addr_inc = (addr_ff == `SCRP_ADDR_TOP) ? 8'h00 : addr_ff + 8'h01;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = bit_cnt_ff;
        nxt_rx = rx_ff;
        nxt_addr = addr_ff;
        if (!cs_act) begin
            nxt_state = scrp_pkg::st_cmd;
            nxt_cnt = 3'h0;
        end else if (sck_rise) begin
            nxt_rx = rx_byte;
            nxt_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
                case (state_ff)
                    scrp_pkg::st_cmd: begin
                        if (rx_byte == `SCRP_CMD_READ) begin
                            nxt_state = scrp_pkg::st_addr_rd;
                        end else if (rx_byte == `SCRP_CMD_WRITE) begin
                            nxt_state = scrp_pkg::st_addr_wr;
                        end else begin
                            nxt_state = scrp_pkg::st_skip;
                        end
                    end
                    scrp_pkg::st_addr_rd: begin
                        nxt_addr = rx_byte;
                        nxt_state = scrp_pkg::st_read;
                    end
                    scrp_pkg::st_addr_wr: begin
                        nxt_addr = rx_byte;
                        nxt_state = scrp_pkg::st_write;
                    end
                    scrp_pkg::st_read: nxt_addr = addr_inc;
                    scrp_pkg::st_write: nxt_addr = addr_inc;
                    default: nxt_state = state_ff;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= scrp_pkg::st_cmd;
            bit_cnt_ff <= 3'h0;
            rx_ff <= 8'h00;
            addr_ff <= 8'h00;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_cnt;
            rx_ff <= nxt_rx;
            addr_ff <= nxt_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    assign wr_hit = cs_act && byte_done && (state_ff == scrp_pkg::st_write);
    assign mem_wr = wr_hit && !is_special(addr_ff);

    // read port follows nxt_addr so data for addr_ff is ready one cycle on
    scrp_mem u_mem (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .wr_en(mem_wr),
        .wr_addr(addr_ff),
        .wr_data(rx_byte),
        .rd_addr(nxt_addr),
        .rd_data(mem_rdata)
    );

    assign rd_byte = is_special(addr_ff) ?
        reg_read(addr_ff, start_ff, stat_ff, mask_ff) : mem_rdata;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_ff <= `SCRP_START_RST;
            mask_ff <= `SCRP_MASK_RST;
        end else if (clk_en && wr_hit) begin
            if (addr_ff == `SCRP_REG_START) begin
                start_ff <= rx_byte[`SCRP_START_RUN_BIT];
            end else if (addr_ff == `SCRP_REG_IRQ_MASK) begin
                mask_ff <= rx_byte[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read shifter: loads on the first falling edge of each data byte

    assign rd_load = cs_act && sck_fall && (state_ff == scrp_pkg::st_read) &&
        (bit_cnt_ff == 3'h0);
    assign rd_shift = cs_act && sck_fall && (state_ff == scrp_pkg::st_read) &&
        (bit_cnt_ff != 3'h0);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sdo_ff <= 1'b0;
            tx_ff <= 8'h00;
        end else if (clk_en) begin
            if (rd_load) begin
                sdo_ff <= rd_byte[7];
                tx_ff <= {rd_byte[6:0], 1'b0};
            end else if (rd_shift) begin
                sdo_ff <= tx_ff[7];
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: a new event beats the clear from the same read

    assign stat_clr = (rd_load && (addr_ff == `SCRP_REG_IRQ_STAT)) ? 5'h1f : 5'h00;
    assign nxt_stat = (stat_ff & ~stat_clr) | {wake_event, irq_event};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat_ff <= `SCRP_STAT_RST;
            irq_n_ff <= 1'b1;
            wake_n_ff <= 1'b1;
        end else if (clk_en) begin
            stat_ff <= nxt_stat;
            irq_n_ff <= !(|(stat_ff[3:0] & mask_ff[3:0]));
            wake_n_ff <= !(stat_ff[`SCRP_WAKE_BIT] && mask_ff[`SCRP_WAKE_BIT]);
        end
    end

    assign serial_data_out = sdo_ff;
    assign serial_data_out_oe = client_mode_ff && !lvl_ff.cs_n;
    assign switch_run = start_ff;
    assign irq_out_n = irq_n_ff;
    assign wake_event_out_n = wake_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    cmd_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && cs_act && byte_done && state_ff == scrp_pkg::st_cmd &&
        rx_byte != `SCRP_CMD_READ && rx_byte != `SCRP_CMD_WRITE
        |=> state_ff == scrp_pkg::st_skip)
        else $error("unknown command not ignored");

    addr_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && wr_hit |=> addr_ff == (($past(addr_ff) == `SCRP_ADDR_TOP) ?
        8'h00 : $past(addr_ff) + 8'h01))
        else $error("address did not advance after byte");

    addr_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && cs_act && byte_done && state_ff == scrp_pkg::st_read &&
        addr_ff == `SCRP_ADDR_TOP |=> addr_ff == 8'h00)
        else $error("address did not wrap to zero");

    select_end_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && !cs_act |=> state_ff == scrp_pkg::st_cmd && bit_cnt_ff == 3'h0)
        else $error("select high did not end access");

    mask_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && wr_hit && addr_ff == `SCRP_REG_IRQ_MASK |=> mask_ff == $past(rx_byte[4:0]))
        else $error("mask write not stored");

    rise_sample_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && cs_act && sck_rise |=> rx_ff[0] == $past(nxt_lvl.sdi))
        else $error("input not sampled on rising edge");

    fall_only_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(clk_en && (rd_load || rd_shift)) |=> $stable(sdo_ff))
        else $error("output changed off a falling edge");

    read_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && rd_load |=> sdo_ff == $past(rd_byte[7]) && tx_ff[7] == $past(rd_byte[6]))
        else $error("read byte not loaded");

    start_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst) |-> start_ff && switch_run)
        else $error("switch not running after reset");

    read_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && stat_clr[0] && irq_event == 4'h0 && !wake_event |=> stat_ff == 5'h00)
        else $error("status not cleared by read");

    event_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && irq_event[0] |=> stat_ff[0])
        else $error("event not recorded");

    irq_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && |(stat_ff[3:0] & mask_ff[3:0]) |=> !irq_out_n)
        else $error("interrupt output not asserted");

    wake_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && !mask_ff[`SCRP_WAKE_BIT] |=> wake_event_out_n)
        else $error("masked wake event reached output");

    strap_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
        serial_data_out_oe |-> client_mode_ff && strap_done_ff)
        else $error("output driven outside client mode");

endmodule // scrp_top

// file: test/scrp_host_model.sv
module scrp_host_model (
    input wire logic ref_clk,
    output logic serial_clk,
    output logic client_select_n,
    output logic host_out_data,
    input wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // 8 ref periods a bit, 320 ns, inside the 25 MHz ceiling
    localparam int HALF = 4;

    scrp_pkg::scrp_byte_t wbuf [256];
    scrp_pkg::scrp_byte_t rbuf [256];

    // clock idles low outside frames
    initial begin
        serial_clk = 1'b0;
        client_select_n = 1'b1;
        host_out_data = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic shift_bit(input logic b, output logic r);
        host_out_data = b; // set while clock low, taken at rise
        repeat (HALF) @(negedge ref_clk);
        r = serial_data_out; // moved on the last fall, settled by now
        serial_clk = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        serial_clk = 1'b0;
    endtask

    // command, one address byte, n data bytes, then tail bits of a cut byte
    task automatic xfer(input scrp_pkg::scrp_byte_t cmd, input scrp_pkg::scrp_byte_t addr,
            input int n, input int tail);
        logic r;
        scrp_pkg::scrp_byte_t v;
        @(negedge ref_clk);
        client_select_n = 1'b0;
        repeat (HALF) @(negedge ref_clk);
        for (int k = 0; k < 8; k++) shift_bit(cmd[7-k], r);
        for (int k = 0; k < 8; k++) shift_bit(addr[7-k], r); // msb first
        for (int i = 0; i < n; i++) begin
            // bytes back to back, no gaps
            for (int k = 0; k < 8; k++) begin
                shift_bit(wbuf[i][7-k], r);
                v[7-k] = r;
            end
            rbuf[i] = v;
        end
        for (int k = 0; k < tail; k++) shift_bit(wbuf[n][7-k], r);
        repeat (HALF) @(negedge ref_clk);
        client_select_n = 1'b1;
        // released line must not keep showing the last bit
        host_out_data = ~host_out_data;
        repeat (2 * HALF) @(negedge ref_clk); // select high between frames
    endtask
endmodule // scrp_host_model

// file: test/spi_client_register_port_tb.sv
`include "scrp_regs.svh"

module spi_client_register_port_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk, rst, clk_en, wake_event;
    logic serial_clk, client_select_n, host_out_data, serial_data_out_in;
    logic serial_data_out, serial_data_out_oe, switch_run, irq_out_n, wake_event_out_n;
    logic [3:0] irq_event;
    int bad_count, checked;

    // pull-down on the output pin straps client mode
    assign serial_data_out_in = serial_data_out_oe ? serial_data_out : 1'b0;

    scrp_top i_dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .serial_clk(serial_clk),
        .client_select_n(client_select_n), .host_out_data(host_out_data),
        .serial_data_out_in(serial_data_out_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .irq_event(irq_event),
        .wake_event(wake_event), .switch_run(switch_run), .irq_out_n(irq_out_n),
        .wake_event_out_n(wake_event_out_n)
    );

    // host reads the pin, so a released line shows the pull-down
    scrp_host_model i_host (
        .ref_clk(ref_clk), .serial_clk(serial_clk), .client_select_n(client_select_n),
        .host_out_data(host_out_data), .serial_data_out(serial_data_out_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input scrp_pkg::scrp_byte_t a, input scrp_pkg::scrp_byte_t d);
        i_host.wbuf[0] = d;
        i_host.xfer(`SCRP_CMD_WRITE, a, 1, 0);
    endtask

    task automatic rd(input scrp_pkg::scrp_byte_t a, output scrp_pkg::scrp_byte_t d);
        i_host.xfer(`SCRP_CMD_READ, a, 1, 0);
        d = i_host.rbuf[0];
    endtask

    // hang guard, far above the longest sequence
    initial begin
        repeat (100000) @(posedge ref_clk);
        check("watchdog", 8'h01, 8'h00);
        give_verdict;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        scrp_pkg::scrp_byte_t v, m;
        rst = 1'b1;
        clk_en = 1'b1;
        irq_event = 4'h0;
        wake_event = 1'b0;
        bad_count = 0;
        checked = 0;
        repeat (3) @(negedge ref_clk);
        check("run in reset", {7'h00, switch_run}, 8'h01);
        check("irq pins in reset", {6'h00, irq_out_n, wake_event_out_n}, 8'h03);
        check("oe in reset", {7'h00, serial_data_out_oe}, 8'h00);
        @(negedge ref_clk);
        rst = 1'b0;
        repeat (16) @(negedge ref_clk);
        // fill plain storage around the flop registers, so no read prefetch is unknown
        for (int i = 0; i < 131; i++) i_host.wbuf[i] = 8'h7e + 8'(i);
        i_host.xfer(`SCRP_CMD_WRITE, 8'h7e, 131, 0);
        for (int i = 0; i < 122; i++) i_host.wbuf[i] = 8'h02 + 8'(i);
        i_host.xfer(`SCRP_CMD_WRITE, 8'h02, 122, 0);
        i_host.xfer(`SCRP_CMD_READ, 8'hff, 2, 0);
        check("sweep ff", i_host.rbuf[0], 8'hff);
        check("sweep 00", i_host.rbuf[1], 8'h00);
        $display("test fill done");
        rd(`SCRP_REG_START, v);
        check("start reg reset", v, 8'h01);
        rd(`SCRP_REG_IRQ_MASK, v);
        check("mask reg reset", v, 8'h00);
        rd(`SCRP_REG_IRQ_STAT, v);
        check("status reg reset", v, 8'h00);
        $display("test reset done");

        wr(`SCRP_REG_START, 8'h00);
        check("run after stop", {7'h00, switch_run}, 8'h00);
        // burst over the top address, restarting the switch on the way
        i_host.wbuf[0] = 8'h5a;
        i_host.wbuf[1] = 8'hc3;
        i_host.wbuf[2] = 8'h96;
        i_host.wbuf[3] = 8'h01;
        i_host.xfer(`SCRP_CMD_WRITE, 8'hfe, 4, 0);
        check("run after burst", {7'h00, switch_run}, 8'h01);
        i_host.xfer(`SCRP_CMD_READ, 8'hfe, 4, 0);
        check("burst fe", i_host.rbuf[0], 8'h5a);
        check("burst ff", i_host.rbuf[1], 8'hc3);
        check("burst 00", i_host.rbuf[2], 8'h96);
        check("burst 01", i_host.rbuf[3], 8'h01);
        $display("test burst wrap done");

        wr(8'h42, 8'h77);
        wr(8'h40, 8'ha5);
        wr(8'h10, 8'h3c);
        i_host.wbuf[0] = 8'h00;
        i_host.xfer(8'h05, 8'h40, 1, 0);
        // select raised four bits into the second byte
        i_host.wbuf[0] = 8'h11;
        i_host.wbuf[1] = 8'h22;
        i_host.xfer(`SCRP_CMD_WRITE, 8'h41, 1, 4);
        check("oe after frame", {7'h00, serial_data_out_oe}, 8'h00);
        rd(8'h10, v);
        check("random 10", v, 8'h3c);
        rd(8'h40, v);
        check("unknown command", v, 8'ha5);
        rd(8'h41, v);
        check("aborted first", v, 8'h11);
        rd(8'h42, v);
        check("aborted partial", v, 8'h77);
        wr(`SCRP_REG_IRQ_STAT, 8'h1f);
        rd(`SCRP_REG_IRQ_STAT, v);
        check("status write", v, 8'h00);
        $display("test access done");

        // each condition masked first, then unmasked, then read away
        for (int i = 0; i < 5; i++) begin
            m = 8'h01 << i;
            wr(`SCRP_REG_IRQ_MASK, 8'h1f & ~m);
            @(negedge ref_clk);
            if (i < 4) irq_event[i] = 1'b1;
            else wake_event = 1'b1;
            @(negedge ref_clk);
            irq_event = 4'h0;
            wake_event = 1'b0;
            repeat (3) @(negedge ref_clk);
            check("masked pins", {6'h00, irq_out_n, wake_event_out_n}, 8'h03);
            wr(`SCRP_REG_IRQ_MASK, m);
            check("unmasked pins", {6'h00, irq_out_n, wake_event_out_n},
                (i < 4) ? 8'h01 : 8'h02);
            rd(`SCRP_REG_IRQ_STAT, v);
            check("status bit", v, m);
            check("cleared pins", {6'h00, irq_out_n, wake_event_out_n}, 8'h03);
        end
        $display("test interrupts done");

        // an event while the clock enable is low is lost
        clk_en = 1'b0;
        irq_event = 4'h1;
        repeat (2) @(negedge ref_clk);
        irq_event = 4'h0;
        clk_en = 1'b1;
        rd(`SCRP_REG_IRQ_STAT, v);
        check("frozen event", v, 8'h00);
        check("frozen pins", {6'h00, irq_out_n, wake_event_out_n}, 8'h03);
        $display("test freeze done");
        give_verdict;
    end
endmodule // spi_client_register_port_tb
